// file: core/ods_pkg.sv
// Purpose: shared constants, field helpers and register map of the octal
//          converter serial loader
// Assumes: 32-bit classic wishbone, byte addresses, one register per word
// Notes:   command word layout on the wire is select, range, code (msb first)
//
// How it works
// - each falling serial clock edge with the word-latch strobe high samples the data pin into the shift register.
// - a command word is 12 bits: an 8-bit code, a 3-bit channel select and a range bit.
// - command bits arrive most significant bit first.
// - bits shift in only while the word-latch strobe is high, and the host holds it high.
// - with the update strobe low, a word-latch fall updates the addressed output at once.
// - with the update strobe high, latching a word changes no output, only a held value.
// - a falling update strobe copies every held value into all eight outputs together.
// - select values zero to seven, msb to lsb, address channels a to h in order.
// - the range bit is stored per channel: zero is unity gain, one is double gain.
// - the code is plain unsigned binary from 0 to 255.
// - after reset all eight channel codes are zero whatever the link does.
package ods_pkg;
   localparam int unsigned WORD_W     = 12;
   localparam int unsigned CODE_W     = 8;
   localparam int unsigned SEL_W      = 3;
   localparam int unsigned ENTRY_W    = 9;
   localparam int unsigned NUM_CH     = 8;
   localparam int unsigned ADR_W      = 8;
   localparam int unsigned CNT_W      = 16;
   // field positions inside the command word
   localparam int unsigned SEL_LSB    = 9;
   localparam int unsigned RANGE_POS  = 8;
   localparam int unsigned CODE_LSB   = 0;
   // register byte offsets
   localparam logic [7:0]  CTRL_OFS   = 8'h00;
   localparam logic [7:0]  STAT_OFS   = 8'h04;
   localparam logic [7:0]  OUT_BASE   = 8'h20;
   localparam logic [7:0]  HOLD_BASE  = 8'h40;
   // control fields and reset values
   localparam int unsigned CTRL_EN_BIT  = 0;
   localparam int unsigned CTRL_UPD_BIT = 1;
   localparam logic        CTRL_EN_RST  = 1'b1;
   localparam logic [8:0]  ENTRY_RST    = 9'h000;
   localparam logic [15:0] CNT_RST      = 16'h0000;
   localparam logic [31:0] RD_ZERO      = 32'h0000_0000;

   // channel select, msb first: 0 is channel a, 7 is channel h
   function automatic logic [2:0] ods_sel(input logic [11:0] w);
      return w[SEL_LSB +: SEL_W];
   endfunction : ods_sel

   // stored entry: range bit above the unsigned code
   function automatic logic [8:0] ods_entry(input logic [11:0] w);
      return {w[RANGE_POS], w[CODE_LSB +: CODE_W]};
   endfunction : ods_entry
endpackage : ods_pkg

// file: core/ods_link_if.sv
// Purpose: carries the shifted command word from the link domain to the core
// Assumes: word is static while the word-latch strobe is low
// Notes:   the strobe itself is the handshake that makes the crossing safe
interface ods_link_if;
   logic [11:0] word;
   modport shifter (output word);
   modport core    (input  word);
endinterface : ods_link_if

// file: core/ods_sync.sv
// Purpose: two-flop synchroniser for asynchronous strobes
// Assumes: inputs are slow levels compared with clk_i
// Notes:   first stage is read by the second stage only
module ods_sync #(
   parameter int unsigned W = 2
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } ods_sync_t;

   ods_sync_t st_q, st_d;

   // shift through both stages; reset parks them high (idle strobes)
   always_comb begin
      st_d    = st_q;
      st_d.s1 = d_i;
      st_d.s2 = st_q.s1;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= '1;
      end else begin
         st_q <= st_d;
      end
   end

   assign q_o = st_q.s2;
endmodule : ods_sync

// file: core/ods_shifter.sv
// Purpose: serial shift register on the link clock
// Assumes: host stops the serial clock before pulsing the word-latch strobe
// Notes:   no reset here; the link clock may be still during system reset
module ods_shifter
   import ods_pkg::*;
(
   input  wire logic   sclk_i,
   input  wire logic   sdata_i,
   input  wire logic   word_latch_strobe_i,
   ods_link_if.shifter lnk
);
   typedef struct packed {
      logic [11:0] word;
   } ods_shift_t;

   ods_shift_t st_q, st_d;

   // msb first, so older bits move up; only the last twelve survive
   always_comb begin
      st_d = st_q;
      if (word_latch_strobe_i) begin
         st_d.word = {st_q.word[WORD_W-2:0], sdata_i};
      end
   end

   // falling edge sampling of the data pin
   always_ff @(negedge sclk_i) begin
      st_q <= st_d;
   end

   assign lnk.word = st_q.word;

   // two shifts in a row: the bit taken first has moved up one place
   sequence s_two_shifts;
      word_latch_strobe_i ##1 word_latch_strobe_i;
   endsequence

   // only freshly shifted bits are compared; older bits stay unknown
   // until the first twelve falls, as this register has no reset
   property p_shift_in;
      @(negedge sclk_i) disable iff (1'b0)
      word_latch_strobe_i |=> st_q.word[0] == $past(sdata_i);
   endproperty
   a_shift_in: assert property (p_shift_in) else $error("shift lost a bit");

   property p_shift_order;
      @(negedge sclk_i) disable iff (1'b0)
      s_two_shifts |=> st_q.word[1] == $past(sdata_i, 2);
   endproperty
   a_shift_order: assert property (p_shift_order) else $error("shift order wrong");

   property p_shift_hold;
      @(negedge sclk_i) disable iff (1'b0)
      !word_latch_strobe_i |=> $stable(st_q.word);
   endproperty
   a_shift_hold: assert property (p_shift_hold) else $error("shift while low");
endmodule : ods_shifter

// file: core/ods_loader.sv
// Purpose: octal converter serial loader: double-buffered channel latches
//          behind a three-wire link, with a wishbone register view
// Assumes: strobes and serial clock come from the host, unrelated to clk_i
// Notes:   outputs are the latched code and range per channel, a..h
//
// Our own choices: the address map and register access over Wishbone.
module ods_loader
   import ods_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             sclk_i,
   input  wire logic             sdata_i,
   input  wire logic             word_latch_strobe_i,
   input  wire logic             output_update_strobe_i,
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [7:0]       wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   output logic      [7:0][7:0]  chan_code_o,
   output logic      [7:0]       chan_range_o
);
   typedef struct packed {
      logic [7:0][8:0] hold;      // holding latches
      logic [7:0][8:0] outl;      // output latches
      logic            link_en;
      logic            soft_upd;
      logic            load_prev;
      logic            upd_prev;
      logic [15:0]     words;
      logic            ack;
      logic [31:0]     rdat;
      logic [1:0]      settle;    // edge detection armed once all ones
   } ods_state_t;

   ods_state_t  st_q, st_d;
   ods_link_if  lnk ();
   logic [1:0]  strobes_s;
   logic        load_s;
   logic        upd_s;
   logic        load_fall;
   logic        upd_fall;
   logic        wb_take;

   // link side runs on the serial clock itself
   ods_shifter u_shift (
      .sclk_i              (sclk_i),
      .sdata_i             (sdata_i),
      .word_latch_strobe_i (word_latch_strobe_i),
      .lnk                 (lnk)
   );

   // both strobes are pins, so they cross before any edge detection
   ods_sync #(.W(2)) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   ({word_latch_strobe_i, output_update_strobe_i}),
      .q_o   (strobes_s)
   );

   // edge detection on the synchronised copies only
   assign load_s    = strobes_s[1];
   assign upd_s     = strobes_s[0];
   // synchroniser parks high in reset, so a strobe held low at release
   // would look like a fall; pin edges count only once settled
   assign load_fall = st_q.load_prev & ~load_s & (&st_q.settle);
   assign upd_fall  = (st_q.upd_prev & ~upd_s & (&st_q.settle)) | st_q.soft_upd;
   assign wb_take   = wb_cyc_i & wb_stb_i & ~st_q.ack;

   // read mux; unmapped offsets read as zero
   function automatic logic [31:0] rd_mux(input ods_state_t s, input logic [7:0] a,
                                          input logic ld, input logic up);
      logic [31:0] r;
      r = RD_ZERO;
      if (a == CTRL_OFS) begin
         r[CTRL_EN_BIT] = s.link_en;
      end else if (a == STAT_OFS) begin
         r = {14'h0000, ld, up, s.words};
      end else if (a[7:5] == OUT_BASE[7:5] && a[1:0] == 2'b00) begin
         r[8:0] = s.outl[a[4:2]];
      end else if (a[7:5] == HOLD_BASE[7:5] && a[1:0] == 2'b00) begin
         r[8:0] = s.hold[a[4:2]];
      end
      return r;
   endfunction : rd_mux

   // next state: link events, update strobe, then bus access
   always_comb begin
      st_d           = st_q;
      st_d.load_prev = load_s;
      st_d.upd_prev  = upd_s;
      st_d.soft_upd  = 1'b0;
      if (!(&st_q.settle)) begin
         st_d.settle = st_q.settle + 2'h1;
      end
      // word is static while the strobe is low, so it is safe to read here
      if (load_fall && st_q.link_en) begin
         st_d.hold[ods_sel(lnk.word)] = ods_entry(lnk.word);
         st_d.words = st_q.words + 16'h0001;
         if (!upd_s) begin
            st_d.outl[ods_sel(lnk.word)] = ods_entry(lnk.word);
         end
      end
      // simultaneous update takes the newest held values
      if (upd_fall) begin
         st_d.outl = st_d.hold;
      end
      // classic single cycle: take, answer the next cycle, drop after
      st_d.ack = wb_take;
      if (wb_take) begin
         st_d.rdat = rd_mux(st_q, wb_adr_i, load_s, upd_s);
         if (wb_we_i && wb_sel_i[0] && wb_adr_i == CTRL_OFS) begin
            st_d.link_en  = wb_dat_i[CTRL_EN_BIT];
            st_d.soft_upd = wb_dat_i[CTRL_UPD_BIT];
         end
      end
   end

   // register everything; reset clears all codes and ranges
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q.hold      <= {NUM_CH{ENTRY_RST}};
         st_q.outl      <= {NUM_CH{ENTRY_RST}};
         st_q.link_en   <= CTRL_EN_RST;
         st_q.soft_upd  <= 1'b0;
         st_q.load_prev <= 1'b1;
         st_q.upd_prev  <= 1'b1;
         st_q.words     <= CNT_RST;
         st_q.ack       <= 1'b0;
         st_q.rdat      <= RD_ZERO;
         st_q.settle    <= 2'h0;
      end else begin
         st_q <= st_d;
      end
   end

   // outputs straight from the latches; code is unsigned binary
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         chan_code_o[i]  = st_q.outl[i][CODE_W-1:0];
         chan_range_o[i] = st_q.outl[i][RANGE_POS];
      end
   end

   assign wb_dat_o = st_q.rdat;
   assign wb_ack_o = st_q.ack;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_load_event;
      load_fall && st_q.link_en;
   endsequence

   sequence s_update_event;
      upd_fall;
   endsequence

   property p_direct_load;
      logic [11:0] w;
      (s_load_event and (!upd_s, w = lnk.word))
         |=> st_q.outl[ods_sel(w)] == ods_entry(w);
   endproperty
   a_direct_load: assert property (p_direct_load) else $error("direct load missed");

   property p_held_only;
      (s_load_event and (upd_s && st_q.upd_prev && !st_q.soft_upd))
         |=> $stable(st_q.outl);
   endproperty
   a_held_only: assert property (p_held_only) else $error("output moved while held");

   property p_update_all;
      s_update_event |=> st_q.outl == st_q.hold;
   endproperty
   a_update_all: assert property (p_update_all) else $error("update not applied");

   property p_hold_decode;
      logic [11:0] w;
      (s_load_event, w = lnk.word)
         |=> st_q.hold[ods_sel(w)] == ods_entry(w) && st_q.words == $past(st_q.words) + 16'h0001;
   endproperty
   a_hold_decode: assert property (p_hold_decode) else $error("wrong channel held");

   property p_range_kept;
      logic [11:0] w;
      (s_load_event, w = lnk.word)
         |=> st_q.hold[ods_sel(w)][RANGE_POS] == w[RANGE_POS];
   endproperty
   a_range_kept: assert property (p_range_kept) else $error("range bit lost");

   property p_reset_zero;
      @(posedge clk_i) disable iff (1'b0)
      rst_i |=> st_q.outl == '0 && st_q.hold == '0 && chan_code_o == '0;
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("codes not cleared");

   property p_no_event_stable;
      !load_fall && !upd_fall |=> $stable(st_q.outl);
   endproperty
   a_no_event_stable: assert property (p_no_event_stable) else $error("spurious output change");

   property p_wb_answer;
      wb_take |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_wb_answer: assert property (p_wb_answer) else $error("bus answer timing wrong");

   property p_disabled;
      load_fall && !st_q.link_en && !upd_fall |=> $stable(st_q.hold);
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled link wrote");
endmodule : ods_loader

// file: tb/ods_host.sv
// Purpose: host side of the three-wire link plus the update strobe
// Assumes: link clock idles low and runs only inside a frame
// Notes:   data line shows the inverse of its last bit once released
module ods_host (
   output logic sclk_o,
   output logic sdata_o,
   output logic latch_o,
   output logic update_o
);
   timeunit 1ns;
   timeprecision 100ps;

   // idle levels: latch strobe high, direct mode
   initial begin
      sclk_o   = 1'b0;
      sdata_o  = 1'b0;
      latch_o  = 1'b1;
      update_o = 1'b0;
   end

   // n bits msb first at 48 ns; sixteen bits go as two bursts of eight
   task automatic send(input logic [15:0] w, input int n);
      #7;
      for (int i = n - 1; i >= 0; i--) begin
         if (i == 7 && n == 16) #100;
         sdata_o = w[i];
         sclk_o = 1'b1;
         #24 sclk_o = 1'b0;
         #24;
      end
      sdata_o = ~sdata_o; // released line must not hold the last bit
      #40 latch_o = 1'b0;
      #260 latch_o = 1'b1;
      #60;
   endtask : send

   // long hold so the synchroniser cannot miss the level
   task automatic set_upd(input logic v);
      update_o = v;
      #300;
   endtask : set_upd
endmodule : ods_host

// file: tb/ods_loader_tb.sv
// Purpose: self-checking bench for the octal converter serial loader
// Assumes: host model drives the link, bench drives wishbone
// Notes:   expected outputs kept in a shadow of hold and output latches
module ods_loader_tb
   import ods_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0][7:0] CODES = 64'hFF80_7F01_C35A_A500;
   logic            clk = 1'b0;
   logic            rst = 1'b1;
   logic            cyc = 1'b0;
   logic            stb = 1'b0;
   logic            we = 1'b0;
   logic [7:0]      adr = 8'h00;
   logic [31:0]     wdat = 32'h0000_0000;
   logic [31:0]     rdat;
   logic [31:0]     q;
   logic            ack;
   logic [7:0][7:0] code;
   logic [7:0]      range_double_bit;
   logic            sclk, sdata, latch, upd;
   logic [7:0][7:0] exp_code = '0;
   logic [7:0][7:0] hold_code = '0;
   logic [7:0]      exp_rng = '0;
   logic [7:0]      hold_rng = '0;
   int              error_cnt = 0;
   int              checked = 0;
   int              cycles = 0;

   ods_host host (.sclk_o(sclk), .sdata_o(sdata), .latch_o(latch), .update_o(upd));
   ods_loader uut (.clk_i(clk), .rst_i(rst), .sclk_i(sclk), .sdata_i(sdata),
      .word_latch_strobe_i(latch), .output_update_strobe_i(upd), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .chan_code_o(code), .chan_range_o(range_double_bit));

   // 250 MHz system clock
   always #2 clk = ~clk;

   // cycle ceiling, about eleven times the expected run
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         error_cnt++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : complete_run

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // classic single cycle; waits for ack, takes data at that edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1);
      q = rdat;
      chk("wb_ack_lat", n, 32'h0000_0002);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask : wb

   task automatic chk_all(input string nm);
      for (int c = 0; c < 8; c++) begin
         chk(nm, {24'h0, code[c]}, {24'h0, exp_code[c]});
         chk(nm, {31'h0, range_double_bit[c]}, {31'h0, exp_rng[c]});
      end
   endtask : chk_all

   // one word; outputs follow at once only in direct mode
   task automatic put(input logic [2:0] ch, input logic r, input logic [7:0] c, input int n);
      host.send({4'h5, ch, r, c}, n);
      hold_code[ch] = c;
      hold_rng[ch] = r;
      if (upd === 1'b0) begin
         exp_code[ch] = c;
         exp_rng[ch] = r;
      end
   endtask : put

   task automatic t_reset();
      chk_all("reset_out");
      wb(1'b0, CTRL_OFS, 32'h0);
      chk("ctrl_rst", q, 32'h1);
      wb(1'b0, 8'h10, 32'h0);
      chk("unmapped", q, RD_ZERO);
      for (int c = 0; c < 8; c++) begin
         wb(1'b0, OUT_BASE + 8'(4 * c), 32'h0);
         chk("out_reg", q, RD_ZERO);
      end
      $display("test reset done");
   endtask : t_reset

   task automatic t_direct();
      for (int c = 0; c < 8; c++) begin
         put(3'(c), c[0], CODES[c], 12);
         chk_all("direct");
      end
      $display("test direct done");
   endtask : t_direct

   task automatic t_defer();
      host.set_upd(1'b1);
      put(3'h2, 1'b1, 8'h3C, 12);
      put(3'h5, 1'b0, 8'h81, 16);
      chk_all("held");
      wb(1'b0, HOLD_BASE + 8'h08, 32'h0);
      chk("hold_reg", q, 32'h0000_013C);
      host.set_upd(1'b0);
      exp_code = hold_code;
      exp_rng = hold_rng;
      chk_all("update");
      $display("test deferred done");
   endtask : t_defer

   task automatic t_long();
      put(3'h6, 1'b1, 8'h96, 16);
      chk_all("long_word");
      wb(1'b1, CTRL_OFS, 32'h0);
      host.send(16'h00AA, 12);
      chk_all("link_off");
      wb(1'b1, CTRL_OFS, 32'h1);
      host.set_upd(1'b1);
      put(3'h1, 1'b0, 8'h44, 12);
      chk_all("soft_held");
      wb(1'b1, CTRL_OFS, 32'h0000_0003);
      exp_code = hold_code;
      exp_rng = hold_rng;
      chk_all("soft_upd");
      host.set_upd(1'b0);
      wb(1'b0, CTRL_OFS, 32'h0);
      chk("ctrl_rd", q, 32'h0000_0001);
      wb(1'b0, STAT_OFS, 32'h0);
      chk("status", q, 32'h0002_000C);
      $display("test long and disable done");
   endtask : t_long

   // reset for 8 cycles, then the scenarios in turn
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_direct();
      t_defer();
      t_long();
      complete_run();
   end
endmodule : ods_loader_tb
